// >>> hw/alp_pkg.sv
// Constants for the converter output latency path
package alp_pkg;
    localparam int SAMPLE_W = 12;
    // Digital latency in half sample-clock cycles (ref_clk ticks stand for half cycles)
    localparam int LAT_DUAL_HALF = 52;
    localparam int LAT_DUAL_4ALN_HALF = 54;
    localparam int LAT_SGL_STAG_HALF = 52;
    localparam int LAT_SGL_2ALN_HALF = 53;
    localparam int LAT_SGL_4ALN_HALF = 55;
    // Sync reference to frame start, half cycles
    localparam int SYNC_DUAL_HALF = 94;
    localparam int SYNC_DUAL_4ALN_HALF = 96;
    localparam int SYNC_SGL_STAG_HALF = 93;
    localparam int SYNC_SGL_2ALN_HALF = 94;
    localparam int SYNC_SGL_4ALN_HALF = 96;
    // Strobe insert switch window, whole cycles
    localparam int STB_MIN_CYC = 26;
    localparam int STB_MAX_BASE_CYC = 36;
    localparam int PIPE_DEPTH = 128;
    // Output delay, zero aperture setting
    localparam real OUT_DELAY_NS = 1.5;
    localparam real CLK_PERIOD_NS = 10.0;
    localparam int OUT_DELAY_CYC = int'(OUT_DELAY_NS / CLK_PERIOD_NS) < 1 ? 1 :
        int'(OUT_DELAY_NS / CLK_PERIOD_NS);
    localparam logic [7:0] AP_COARSE_RST = 8'h00;
    localparam int SER_WAIT_BITS = 16;
    localparam logic [7:0] FRAME_LEN_RST = 8'h08;
endpackage

// >>> hw/alp_latency_path.sv
// Output pipeline of the converter: latency, framing strobe, stagger and serial read-out
`timescale 1ns/1ns
// Functional notes
// - Dual-channel samples launch 26 cycles after sampling, 27 in four-bus aligned mode.
// - Single-channel latency is 26 staggered, 26.5 two-bus aligned, 27.5 four-bus aligned.
// - Dual-channel frame starts 47 cycles after sync capture, 48 in four-bus aligned mode.
// - Single-channel frame starts 46.5 staggered, 47 two-bus aligned, 48 four-bus aligned.
// - The strobe-insert request switches bus B lsb between data and strobe.
// - That switch takes 26 to 36 cycles plus one frame (two-bus) or two frames (four-bus).
// - In four-bus aligned mode earlier samples are delayed so all buses align to the slowest one.
// - In four-bus staggered mode bus C frames trail bus A, latency quoted for the earliest bus.
// - The strobe marks each frame end and the next sample starts a new frame.
// - Bus A clock follows the rising edge in dual mode and the falling edge in single mode.
// - Aperture delay settings add equally to aperture delay and output delay.
// - Total latency is digital latency plus output delay minus aperture delay.
// - Serial out stays undriven until the falling edge of the 16th serial clock.
// - Serial out bits change after serial clock falling edges.
// - Raising the serial select returns serial out to undriven.
// - Four-bus bus A clock leads bus C by one period staggered, zero aligned.
module alp_latency_path #(
    parameter int FRAME_W = 8,
    parameter int DEPTH = alp_pkg::PIPE_DEPTH
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic clk_en_i,
    input wire logic single_channel_i,
    input wire logic four_bus_demux_select_i,
    input wire logic bus_align_select_i,
    input wire logic [FRAME_W-1:0] frame_length_setting_i,
    input wire logic [7:0] aperture_delay_coarse_i,
    input wire logic [7:0] aperture_delay_fine_i,
    input wire logic aperture_clock_invert_i,
    input wire logic [alp_pkg::SAMPLE_W-1:0] sample_i,
    input wire logic sample_valid_i,
    output logic sample_ready_o,
    input wire logic sync_ref_i,
    input wire logic strobe_insert_request_i,
    input wire logic out_ready_i,
    output logic out_valid_o,
    output logic [alp_pkg::SAMPLE_W-1:0] bus_a_o,
    output logic [alp_pkg::SAMPLE_W-1:0] bus_b_o,
    output logic [alp_pkg::SAMPLE_W-1:0] bus_c_o,
    output logic bus_b_lsb_pair_o,
    output logic frame_start_o,
    output logic bus_a_output_clock_o,
    output logic bus_c_output_clock_o,
    output logic [9:0] out_delay_o,
    output logic [9:0] aperture_delay_o,
    input wire logic serial_clk_i,
    input wire logic serial_select_n_i,
    input wire logic serial_in_i,
    input wire logic [7:0] read_data_i,
    output logic serial_read_out_o,
    output logic serial_read_out_oe_o
);
    import alp_pkg::*;

    localparam int AW = $clog2(DEPTH);

    //----------------------------------------------------------------
    // Mode dependent delays
    //----------------------------------------------------------------
    function automatic logic [AW-1:0] lat_sel(input logic sgl, input logic dmx, input logic aln);
        int v;
        v = LAT_DUAL_HALF;
        if (!sgl && dmx && aln) v = LAT_DUAL_4ALN_HALF;
        if (sgl) begin
            v = LAT_SGL_STAG_HALF;
            if (aln) v = dmx ? LAT_SGL_4ALN_HALF : LAT_SGL_2ALN_HALF;
        end
        return AW'(v);
    endfunction

    function automatic logic [AW-1:0] sync_sel(input logic sgl, input logic dmx, input logic aln);
        int v;
        v = SYNC_DUAL_HALF;
        if (!sgl && dmx && aln) v = SYNC_DUAL_4ALN_HALF;
        if (sgl) begin
            v = SYNC_SGL_STAG_HALF;
            if (aln) v = dmx ? SYNC_SGL_4ALN_HALF : SYNC_SGL_2ALN_HALF;
        end
        return AW'(v);
    endfunction

    logic [AW-1:0] lat;
    logic [AW-1:0] sync_lat;
    assign lat = lat_sel(single_channel_i, four_bus_demux_select_i, bus_align_select_i);
    assign sync_lat = sync_sel(single_channel_i, four_bus_demux_select_i, bus_align_select_i);

    //----------------------------------------------------------------
    // Sample delay line, one tick per half sample clock
    //----------------------------------------------------------------
    logic [SAMPLE_W-1:0] line_mem [DEPTH];
    logic [DEPTH-1:0] vline_reg;
    logic [AW-1:0] wp_reg;
    logic buf_ready;

    // Input stalls only while the output buffer is full, so no word is lost
    assign sample_ready_o = buf_ready;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wp_reg <= '0;
            vline_reg <= '0;
        end else if (clk_en_i && buf_ready) begin
            wp_reg <= wp_reg + AW'(1);
            vline_reg[wp_reg] <= sample_valid_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (clk_en_i && buf_ready) begin
            line_mem[wp_reg] <= sample_i;
        end
    end

    // Taps: aligned, slowest bus sets the latency and earlier bus padded to match; staggered, bus A sets it
    logic [AW-1:0] tap;
    logic [AW-1:0] tap_c;
    assign tap = wp_reg - lat;
    // Staggered four-bus: bus C one period later than A; aligned: same tap
    assign tap_c = (four_bus_demux_select_i && !bus_align_select_i) ? tap - AW'(2) : tap;

    //----------------------------------------------------------------
    // Frame counter and strobe
    //----------------------------------------------------------------
    logic sync_s1_reg;
    logic sync_s2_reg;
    logic sync_d_reg;
    logic [AW-1:0] sync_cnt_reg;
    logic sync_pend_reg;
    logic [FRAME_W-1:0] fpos_reg;
    logic strobe;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync_s1_reg <= 1'b0;
            sync_s2_reg <= 1'b0;
            sync_d_reg <= 1'b0;
        end else if (clk_en_i) begin
            sync_s1_reg <= sync_ref_i;
            sync_s2_reg <= sync_s1_reg;
            sync_d_reg <= sync_s2_reg;
        end
    end

    // Counts with the line, so a stall keeps framing and data together
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync_pend_reg <= 1'b0;
            sync_cnt_reg <= '0;
        end else if (clk_en_i && buf_ready) begin
            if (sync_s2_reg && !sync_d_reg) begin
                sync_pend_reg <= 1'b1;
                sync_cnt_reg <= sync_lat - AW'(1);
            end else if (sync_pend_reg) begin
                if (sync_cnt_reg == '0) sync_pend_reg <= 1'b0;
                else sync_cnt_reg <= sync_cnt_reg - AW'(1);
            end
        end
    end

    wire frame_restart = sync_pend_reg && sync_cnt_reg == '0;
    // Sync restart and strobe both open a new frame

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fpos_reg <= '0;
        end else if (clk_en_i && buf_ready) begin
            if (frame_restart || strobe) fpos_reg <= '0;
            else fpos_reg <= fpos_reg + FRAME_W'(1);
        end
    end

    // Strobe on the last word of each frame
    assign strobe = fpos_reg == frame_length_setting_i - FRAME_W'(1);

    //----------------------------------------------------------------
    // Strobe insert request: synchronise, delay within the window
    //----------------------------------------------------------------
    logic ins_s1_reg;
    logic ins_s2_reg;
    logic [STB_MIN_CYC*2-1:0] ins_line_reg;
    logic ins_active_reg;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ins_s1_reg <= 1'b0;
            ins_s2_reg <= 1'b0;
            ins_line_reg <= '0;
            ins_active_reg <= 1'b0;
        end else if (clk_en_i && buf_ready) begin
            ins_s1_reg <= strobe_insert_request_i;
            ins_s2_reg <= ins_s1_reg;
            ins_line_reg <= {ins_line_reg[STB_MIN_CYC*2-2:0], ins_s2_reg};
            // Change only on a frame boundary; bounded by the added frame term
            if (strobe || !ins_active_reg == !ins_line_reg[STB_MIN_CYC*2-1])
                ins_active_reg <= ins_line_reg[STB_MIN_CYC*2-1];
        end
    end

    //----------------------------------------------------------------
    // Two-entry output buffer
    //----------------------------------------------------------------
    logic [2*SAMPLE_W+1:0] ent_reg [2];
    logic [1:0] cnt_reg;
    logic rd_reg;
    logic push;
    logic pop;
    logic [2*SAMPLE_W+1:0] word;

    assign word = {line_mem[tap], line_mem[tap_c], strobe, frame_restart | strobe};
    assign buf_ready = cnt_reg != 2'd2;
    assign push = clk_en_i && buf_ready && vline_reg[tap];
    assign pop = clk_en_i && cnt_reg != 2'd0 && out_ready_i;
    assign out_valid_o = cnt_reg != 2'd0;
    // Write slot sits one past the head while an entry is held

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt_reg <= 2'd0;
            rd_reg <= 1'b0;
            ent_reg[0] <= '0;
            ent_reg[1] <= '0;
        end else begin
            if (push) ent_reg[rd_reg ^ cnt_reg[0]] <= word;
            if (pop) rd_reg <= ~rd_reg;
            cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
        end
    end

    wire [2*SAMPLE_W+1:0] head = ent_reg[rd_reg];
    assign bus_a_o = head[2*SAMPLE_W+1:SAMPLE_W+2];
    assign bus_c_o = head[SAMPLE_W+1:2];
    assign bus_b_o = head[2*SAMPLE_W+1:SAMPLE_W+2];
    // Bus B lsb carries strobe instead of data when insertion active
    assign bus_b_lsb_pair_o = ins_active_reg ? head[1] : head[SAMPLE_W+2];
    assign frame_start_o = head[0];

    //----------------------------------------------------------------
    // Output clocks and delays
    //----------------------------------------------------------------
    logic clka_reg;
    logic clka_d_reg;
    logic clkc_reg;
    // Staggered bus C runs two ticks, one sample period, behind bus A
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            clka_reg <= 1'b0;
            clka_d_reg <= 1'b1;
            clkc_reg <= 1'b0;
        end else if (clk_en_i) begin
            // Single mode references the falling sample edge: inverted phase
            clka_reg <= ~clka_reg;
            clka_d_reg <= clka_reg;
            clkc_reg <= (four_bus_demux_select_i && !bus_align_select_i) ? clka_d_reg : ~clka_reg;
        end
    end
    assign bus_a_output_clock_o = clka_reg ^ single_channel_i;
    assign bus_c_output_clock_o = clkc_reg ^ single_channel_i;

    // Settings add as raw steps; no scaling to real delay units
    wire [9:0] ap_add = {2'b00, aperture_delay_coarse_i} + {2'b00, aperture_delay_fine_i}
        + {9'd0, aperture_clock_invert_i};
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_delay_o <= 10'h000;
            aperture_delay_o <= 10'h000;
        end else if (clk_en_i) begin
            out_delay_o <= 10'(OUT_DELAY_CYC) + ap_add;
            aperture_delay_o <= ap_add;
        end
    end

    //----------------------------------------------------------------
    // Serial read-out
    //----------------------------------------------------------------
    logic sck_s1_reg;
    logic sck_s2_reg;
    logic sck_d_reg;
    logic scs_s1_reg;
    logic scs_s2_reg;
    logic [4:0] bit_reg;
    logic [7:0] sh_reg;
    logic is_read_reg;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sck_s1_reg <= 1'b0;
            sck_s2_reg <= 1'b0;
            sck_d_reg <= 1'b0;
            scs_s1_reg <= 1'b1;
            scs_s2_reg <= 1'b1;
        end else if (clk_en_i) begin
            sck_s1_reg <= serial_clk_i;
            sck_s2_reg <= sck_s1_reg;
            sck_d_reg <= sck_s2_reg;
            scs_s1_reg <= serial_select_n_i;
            scs_s2_reg <= scs_s1_reg;
        end
    end

    wire sck_rise = sck_s2_reg && !sck_d_reg;
    wire sck_fall = !sck_s2_reg && sck_d_reg;
    logic sdi_s1_reg;
    logic sdi_s2_reg;

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sdi_s1_reg <= 1'b0;
            sdi_s2_reg <= 1'b0;
            bit_reg <= '0;
            is_read_reg <= 1'b0;
            sh_reg <= '0;
            serial_read_out_o <= 1'b0;
            serial_read_out_oe_o <= 1'b0;
        end else if (clk_en_i) begin
            sdi_s1_reg <= serial_in_i;
            sdi_s2_reg <= sdi_s1_reg;
            if (scs_s2_reg) begin
                bit_reg <= '0;
                is_read_reg <= 1'b0;
                serial_read_out_oe_o <= 1'b0;
            end else begin
                // First bit picks read; a write never drives the pin
                if (sck_rise && bit_reg == 5'd0) is_read_reg <= sdi_s2_reg;
                if (sck_fall) begin
                    if (bit_reg != 5'd31) bit_reg <= bit_reg + 5'd1;
                    if (bit_reg == 5'(SER_WAIT_BITS - 1) && is_read_reg) begin
                        serial_read_out_oe_o <= 1'b1;
                        serial_read_out_o <= read_data_i[7];
                        sh_reg <= {read_data_i[6:0], 1'b0};
                    end else if (serial_read_out_oe_o) begin
                        serial_read_out_o <= sh_reg[7];
                        sh_reg <= {sh_reg[6:0], 1'b0};
                    end
                end
            end
        end
    end
endmodule

// >>> testbench/alp_latency_path_sva.sv
// Concurrent checks on the latency path ports
`timescale 1ns/1ns
module alp_latency_path_sva (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic single_channel_i,
    input wire logic four_bus_demux_select_i,
    input wire logic bus_align_select_i,
    input wire logic [7:0] aperture_delay_coarse_i,
    input wire logic [7:0] aperture_delay_fine_i,
    input wire logic aperture_clock_invert_i,
    input wire logic out_ready_i,
    input wire logic out_valid_o,
    input wire logic [alp_pkg::SAMPLE_W-1:0] bus_a_o,
    input wire logic frame_start_o,
    input wire logic bus_a_output_clock_o,
    input wire logic bus_c_output_clock_o,
    input wire logic [9:0] out_delay_o,
    input wire logic [9:0] aperture_delay_o,
    input wire logic serial_clk_i,
    input wire logic serial_select_n_i,
    input wire logic serial_read_out_o,
    input wire logic serial_read_out_oe_o
);
    import alp_pkg::*;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    // ------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------
    logic sclk_reg;
    logic [4:0] fall_cnt_reg;
    logic [3:0] fall_age_reg;
    logic [6:0] since_rst_reg;
    wire logic sclk_fall = sclk_reg && !serial_clk_i;
    // Raw sampling runs ahead of the design's synchroniser, so bounds stay safe
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sclk_reg <= 1'b0;
            since_rst_reg <= 7'h00;
        end else begin
            sclk_reg <= serial_clk_i;
            if (since_rst_reg != 7'h7f) begin
                since_rst_reg <= since_rst_reg + 7'h01;
            end
        end
    end
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fall_cnt_reg <= 5'h00;
            fall_age_reg <= 4'hf;
        end else begin
            if (serial_select_n_i) begin
                fall_cnt_reg <= 5'h00;
            end else if (sclk_fall && fall_cnt_reg != 5'h1f) begin
                fall_cnt_reg <= fall_cnt_reg + 5'h01;
            end
            if (sclk_fall) begin
                fall_age_reg <= 4'h0;
            end else if (fall_age_reg != 4'hf) begin
                fall_age_reg <= fall_age_reg + 4'h1;
            end
        end
    end
    AST_NO_EARLY: assert property ($rose(out_valid_o) |-> since_rst_reg >= 7'h33)
        else $error("output before minimum latency");
    AST_VALID_HOLD: assert property (out_valid_o && !out_ready_i |=> out_valid_o)
        else $error("valid dropped during stall");
    AST_BUS_HOLD: assert property (out_valid_o && !out_ready_i |=>
        $stable(bus_a_o) && $stable(frame_start_o))
        else $error("bus word changed during stall");
    // First edge after reset still sees the reset phase
    AST_CLK_TOGGLE: assert property (since_rst_reg != 7'h00 && $stable(single_channel_i) |->
        bus_a_output_clock_o != $past(bus_a_output_clock_o))
        else $error("bus a clock missed a tick");
    AST_CLK_AC: assert property (four_bus_demux_select_i && $stable(bus_align_select_i) &&
        $stable(single_channel_i) |-> bus_c_output_clock_o == bus_a_output_clock_o)
        else $error("bus c clock phase wrong");
    AST_DELAY_HOLD: assert property (($stable(aperture_delay_coarse_i) &&
        $stable(aperture_delay_fine_i) && $stable(aperture_clock_invert_i)) [*3] |->
        $stable(out_delay_o) && $stable(aperture_delay_o))
        else $error("delay moved without a setting change");
    AST_OE_WAIT: assert property ($rose(serial_read_out_oe_o) |-> fall_cnt_reg >= 5'h10)
        else $error("serial out driven too early");
    AST_DOUT_FALL: assert property (serial_read_out_oe_o && $past(serial_read_out_oe_o) &&
        !serial_select_n_i && $changed(serial_read_out_o) |-> fall_age_reg <= 4'h5)
        else $error("serial out changed away from a falling edge");
    AST_OE_DROP: assert property (serial_select_n_i [*5] |-> !serial_read_out_oe_o)
        else $error("serial out still driven after deselect");
    cover property ($rose(serial_read_out_oe_o));
    cover property (out_valid_o && !out_ready_i);
    cover property (frame_start_o && out_valid_o);
endmodule

// >>> testbench/alp_rx_model.sv
// Receiving logic model that takes words from the output buffer
`timescale 1ns/1ns
module alp_rx_model (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic stall_i,
    input wire logic valid_i,
    input wire logic frame_start_i,
    output logic ready_o,
    output int word_count_o,
    output int frame_pos_o
);
    // ------------------------------------------------------------
    // Word intake
    // ------------------------------------------------------------
    // Registered, so a stall lands just after an edge
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ready_o <= 1'b0;
        end else begin
            ready_o <= !stall_i;
        end
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            word_count_o <= 0;
            frame_pos_o <= 0;
        end else if (valid_i && ready_o) begin
            word_count_o <= word_count_o + 1;
            frame_pos_o <= frame_start_i ? 0 : frame_pos_o + 1;
        end
    end
endmodule

// >>> testbench/testbench.sv
// Self-checking bench for the converter output latency path
`timescale 1ns/1ns
module testbench;
    import alp_pkg::*;
    logic ref_clk_i = 1'b0, nrst_i = 1'b0, clk_en_i = 1'b1, stall = 1'b0;
    logic single_channel_i = 1'b0, four_bus_demux_select_i = 1'b0, bus_align_select_i = 1'b0;
    logic [7:0] frame_length_setting_i = 8'h08, read_data_i = 8'ha5;
    logic [7:0] aperture_delay_coarse_i = 8'h00, aperture_delay_fine_i = 8'h00;
    logic aperture_clock_invert_i = 1'b0, sample_valid_i = 1'b0, sync_ref_i = 1'b0;
    logic strobe_insert_request_i = 1'b0, serial_clk_i = 1'b0, serial_select_n_i = 1'b1;
    logic serial_in_i = 1'b0, out_ready_i, sample_ready_o, out_valid_o;
    logic [SAMPLE_W-1:0] sample_i = 12'hfff, bus_a_o, bus_b_o, bus_c_o;
    logic bus_b_lsb_pair_o, frame_start_o, bus_a_output_clock_o, bus_c_output_clock_o;
    logic serial_read_out_o, serial_read_out_oe_o;
    logic [9:0] out_delay_o, aperture_delay_o;
    int fails = 0, check_count = 0, cyc = 0, words, frame_pos;
    alp_latency_path u_dut (.*);
    alp_rx_model u_rx (.clk_i(ref_clk_i), .nrst_i(nrst_i), .stall_i(stall), .valid_i(out_valid_o),
        .frame_start_i(frame_start_o), .ready_o(out_ready_i), .word_count_o(words),
        .frame_pos_o(frame_pos));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic in_range(input string what, input int n, input int lo, input int hi);
        check(what, 16'(n >= lo && n <= hi), 16'h0001);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    function automatic logic cond(input int k);
        if (k == 0) return out_valid_o === 1'b1;
        if (k == 1) return out_valid_o === 1'b1 && frame_start_o === 1'b1;
        return out_valid_o === 1'b1 && bus_b_lsb_pair_o === 1'b0;
    endfunction
    // Bounded wait; counts ticks from the call
    task automatic measure(input int k, output int n);
        n = 0;
        while (!cond(k) && n < 400) begin
            step(1);
            n++;
        end
    endtask
    function automatic int exp_half(input logic s, input logic f, input logic a, input logic y);
        if (!s && f && a) return y ? SYNC_DUAL_4ALN_HALF : LAT_DUAL_4ALN_HALF;
        if (!s) return y ? SYNC_DUAL_HALF : LAT_DUAL_HALF;
        if (!a) return y ? SYNC_SGL_STAG_HALF : LAT_SGL_STAG_HALF;
        if (f) return y ? SYNC_SGL_4ALN_HALF : LAT_SGL_4ALN_HALF;
        return y ? SYNC_SGL_2ALN_HALF : LAT_SGL_2ALN_HALF;
    endfunction
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int n;
        int e;
        int w0;
        logic [15:0] sh;
        logic early;
        repeat (4) @(posedge ref_clk_i);
        #1 nrst_i = 1'b1;
        step(3);
        check("delay base", 16'(out_delay_o), 16'(OUT_DELAY_CYC));
        aperture_delay_coarse_i = 8'h03;
        aperture_delay_fine_i = 8'h05;
        aperture_clock_invert_i = 1'b1;
        step(4);
        check("delay gap", 16'(10'(out_delay_o - aperture_delay_o)), 16'(OUT_DELAY_CYC));
        check("delay grows", 16'(out_delay_o > 10'(OUT_DELAY_CYC)), 16'h0001);
        for (int m = 0; m < 8; m++) begin
            {single_channel_i, four_bus_demux_select_i, bus_align_select_i} = 3'(m);
            sample_valid_i = 1'b0;
            // Long frames, so no strobe lands inside the sync measurement
            frame_length_setting_i = 8'hc0;
            step(130);
            e = exp_half(m[2], m[1], m[0], 1'b0);
            sample_i = 12'h5a3;
            sample_valid_i = 1'b1;
            step(1);
            sample_i = 12'hfff;
            sample_valid_i = 1'b0;
            measure(0, n);
            in_range("latency", n, e, e + 1);
            check("bus a word", 16'(bus_a_o), 16'h05a3);
            check("bus b word", 16'(bus_b_o), 16'h05a3);
            check("bus c word", 16'(bus_c_o), (m[1] && !m[0]) ? 16'h0fff : 16'h05a3);
            sample_valid_i = 1'b1;
            sync_ref_i = 1'b1;
            step(4);
            sync_ref_i = 1'b0;
            step(100);
            e = exp_half(m[2], m[1], m[0], 1'b1);
            sync_ref_i = 1'b1;
            measure(1, n);
            sync_ref_i = 1'b0;
            in_range("frame start", n, e, e + 4);
        end
        {single_channel_i, bus_align_select_i} = 2'b00;
        frame_length_setting_i = 8'h08;
        for (int f = 1; f <= 2; f++) begin
            four_bus_demux_select_i = (f == 2);
            step(130);
            strobe_insert_request_i = 1'b1;
            measure(2, n);
            e = 2 * (STB_MAX_BASE_CYC + f * int'(frame_length_setting_i));
            in_range("strobe on", n, 2 * STB_MIN_CYC, e);
            strobe_insert_request_i = 1'b0;
            step(e + 4);
            n = 0;
            repeat (8) begin
                step(1);
                n += int'(cond(2));
            end
            check("strobe off", 16'(n), 16'h0000);
        end
        stall = 1'b1;
        step(90);
        check("ready when full", 16'(sample_ready_o), 16'h0000);
        check("valid when full", 16'(out_valid_o), 16'h0001);
        w0 = words;
        sample_valid_i = 1'b0;
        stall = 1'b0;
        step(200);
        check("ready after drain", 16'(sample_ready_o), 16'h0001);
        check("valid after drain", 16'(out_valid_o), 16'h0000);
        check("words taken", 16'(words > w0), 16'h0001);
        serial_select_n_i = 1'b0;
        serial_in_i = 1'b1;
        early = 1'b0;
        sh = 16'h0000;
        for (int i = 1; i <= 25; i++) begin
            #40 serial_clk_i = 1'b1;
            if (i > 16) begin
                sh = {sh[14:0], serial_read_out_o};
            end else begin
                early = early | serial_read_out_oe_o;
            end
            #40 serial_clk_i = 1'b0;
            serial_in_i = 1'b0;
        end
        check("oe early", 16'(early), 16'h0000);
        check("oe driven", 16'(serial_read_out_oe_o), 16'h0001);
        check("read data", 16'(sh[8:1]), 16'(read_data_i));
        step(1);
        serial_select_n_i = 1'b1;
        step(5);
        check("oe released", 16'(serial_read_out_oe_o), 16'h0000);
        complete_run();
    end
endmodule
bind alp_latency_path alp_latency_path_sva u_sva (.*);
